// ---- verif/cca_pin_model.sv ----
// Purpose: Far side of the channel pins, the count input and the companion timer
// Assumes: Bench calls the tasks; every change lands just after a rising edge
// Notes:   A pin the array drives reads back the array level, else the outside level
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model #(
    parameter int GAP = 6
) (
    // Clock
    input  wire logic        clk_i,
    // Array pin outputs
    input  wire logic [15:0] pin_o,
    input  wire logic [15:0] pin_oe_o,
    // Array inputs
    output logic [15:0]      pin_i,
    output var logic         count_i,
    output var logic         companion_timer_ovf_i
);
    logic [15:0] ext_q = 16'h0000;

    initial begin
        count_i = 1'b0;
        companion_timer_ovf_i = 1'b0;
    end

    // Wire level from both parties
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_q);

    // Settle time lets the array act before the next step
    task automatic set_pins(input logic [15:0] mask, input logic [15:0] val);
        @(posedge clk_i);
        ext_q <= (ext_q & ~mask) | (val & mask);
        repeat (GAP) @(posedge clk_i);
    endtask

    task automatic ext_pulse(input logic comp);
        @(posedge clk_i);
        if (comp) begin
            companion_timer_ovf_i <= 1'b1;
        end else begin
            count_i <= 1'b1;
        end
        @(posedge clk_i);
        companion_timer_ovf_i <= 1'b0;
        count_i <= 1'b0;
        repeat (GAP) @(posedge clk_i);
    endtask
endmodule // cca_pin_model
`default_nettype wire

// ---- verif/test_capture_compare_array.sv ----
// Purpose: Self-checking bench of the capture/compare array over Wishbone
// Assumes: Pins, count input and companion overflow come from cca_pin_model
// Notes:   Timer 0 counts external pulses and timer 1 companion pulses, so every match lands on a known step
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"
module test_capture_compare_array;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic        wb_ack_o;
    logic [31:0] wb_dat_o;
    logic        count_i;
    logic        companion_timer_ovf_i;
    logic [15:0] pin_i;
    logic [15:0] pin_o;
    logic [15:0] pin_oe_o;
    logic [15:0] req_o;
    logic [31:0] q;
    int          failures     = 0;
    int          total_checks = 0;
    int          req_n [16];

    always #20 clk_i = ~clk_i;

    cca_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .companion_timer_ovf_i(companion_timer_ovf_i),
        .count_i(count_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .req_o(req_o));

    cca_pin_model pm (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_i(pin_i),
        .count_i(count_i), .companion_timer_ovf_i(companion_timer_ovf_i));

    // Requests are one-cycle pulses, so counting them per edge is exact
    always @(posedge clk_i) begin
        for (int i = 0; i < 16; i++) begin
            if (req_o[i] === 1'b1) req_n[i]++;
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            failures++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // One classic cycle; the bench timeout is the only limit on the wait
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, 4'hF);
        chk(q, exp, "read");
    endtask

    task automatic pin(input int n, input logic exp);
        chk({31'h0, pin_o[n]}, {31'h0, exp}, "pin level");
    endtask

    task automatic nreq(input int n, input int exp);
        chk(32'(req_n[n]), 32'(exp), "request count");
    endtask

    function automatic logic [7:0] ca(input int n);
        return `CCA_OFS_CCTL + 8'(4 * n);
    endfunction

    function automatic logic [7:0] va(input int n);
        return `CCA_OFS_CVAL + 8'(4 * n);
    endfunction

    function automatic logic [31:0] cc(input cca_pkg::cca_func_t fn, input logic [1:0] md,
                                       input logic ts, input logic se, input logic db);
        return {25'h0, db, se, ts, md, fn};
    endfunction

    initial begin
        for (int i = 0; i < 16; i++) req_n[i] = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CCA_OFS_TCTL0, 32'h0000_0000);
        rd(`CCA_OFS_TREL1, 32'h0000_0000);
        // Byte enables reach one lane at a time
        xfer(1'b1, `CCA_OFS_TREL1, 32'h0000_AABB, 4'h1);
        xfer(1'b1, `CCA_OFS_TREL1, 32'h0000_CC00, 4'h2);
        rd(`CCA_OFS_TREL1, 32'h0000_CCBB);
        rd(ca(5), 32'h0000_0000);
        chk({16'h0, pin_oe_o}, 32'h0000_0000, "enables");
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000);
        // External count input on timer 0
        wr(`CCA_OFS_TCNT0, 32'h0000_0000);
        wr(`CCA_OFS_TCTL0, 32'h0000_0030);
        repeat (5) pm.ext_pulse(1'b0);
        rd(`CCA_OFS_TCNT0, 32'h0000_0005);
        // Capture on rise, fall and both
        wr(ca(1), cc(cca_pkg::CCA_FN_CAP, 2'h1, 1'b0, 1'b0, 1'b0));
        wr(ca(2), cc(cca_pkg::CCA_FN_CAP, 2'h2, 1'b0, 1'b0, 1'b0));
        wr(ca(6), cc(cca_pkg::CCA_FN_CAP, 2'h3, 1'b0, 1'b0, 1'b0));
        wr(`CCA_OFS_TCNT0, 32'h0000_1234);
        pm.set_pins(16'h0046, 16'h0046);
        nreq(1, 1);
        nreq(2, 0);
        nreq(6, 1);
        rd(va(1), 32'h0000_1234);
        wr(`CCA_OFS_TCNT0, 32'h0000_0BCD);
        pm.set_pins(16'h0046, 16'h0000);
        nreq(1, 1);
        nreq(2, 1);
        rd(va(1), 32'h0000_1234);
        rd(va(2), 32'h0000_0BCD);
        rd(va(6), 32'h0000_0BCD);
        // Compare modes 3, 0, 2, 1 on channels 7..10, all at 0020
        wr(`CCA_OFS_TREL0, 32'h0000_FFF0);
        for (int n = 7; n <= 10; n++) wr(va(n), 32'h0000_0020);
        wr(ca(7), cc(cca_pkg::CCA_FN_CMP, 2'h3, 1'b0, 1'b0, 1'b0));
        wr(ca(8), cc(cca_pkg::CCA_FN_CMP, 2'h0, 1'b0, 1'b0, 1'b0));
        wr(ca(9), cc(cca_pkg::CCA_FN_CMP, 2'h2, 1'b0, 1'b0, 1'b0));
        wr(ca(10), cc(cca_pkg::CCA_FN_CMP, 2'h1, 1'b0, 1'b0, 1'b0));
        wr(`CCA_OFS_TCNT0, 32'h0000_001F);
        pm.ext_pulse(1'b0);
        for (int n = 7; n <= 10; n++) nreq(n, 1);
        pin(10, 1'b1);
        pin(7, 1'b1);
        chk({31'h0, pin_oe_o[10]}, 32'h1, "enable");
        wr(`CCA_OFS_TCNT0, 32'h0000_001F);
        pm.ext_pulse(1'b0);
        nreq(8, 2);
        nreq(9, 1);
        pin(10, 1'b0);
        pin(7, 1'b1);
        wr(`CCA_OFS_TCNT0, 32'h0000_FFFF);
        pm.ext_pulse(1'b0);
        pin(7, 1'b0);
        rd(`CCA_OFS_TCNT0, 32'h0000_FFF0);
        wr(`CCA_OFS_TCNT0, 32'h0000_001F);
        pm.ext_pulse(1'b0);
        nreq(9, 2);
        nreq(8, 3);
        pin(7, 1'b1);
        // Double register on pin 3 and single event on channel 12
        wr(va(3), 32'h0000_0040);
        wr(va(11), 32'h0000_0041);
        wr(va(12), 32'h0000_0040);
        wr(ca(3), cc(cca_pkg::CCA_FN_CMP, 2'h1, 1'b0, 1'b0, 1'b1));
        wr(ca(11), cc(cca_pkg::CCA_FN_CMP, 2'h1, 1'b0, 1'b0, 1'b0));
        wr(ca(12), cc(cca_pkg::CCA_FN_CMP, 2'h1, 1'b0, 1'b1, 1'b0));
        wr(`CCA_OFS_TCNT0, 32'h0000_003F);
        pm.ext_pulse(1'b0);
        pin(3, 1'b1);
        pin(12, 1'b1);
        pm.ext_pulse(1'b0);
        pin(3, 1'b0);
        chk({31'h0, pin_oe_o[11]}, 32'h0, "enable");
        xfer(1'b0, ca(12), 32'h0000_0000, 4'hF);
        chk(q & 32'h3, 32'h0, "function");
        wr(`CCA_OFS_TCNT0, 32'h0000_003F);
        pm.ext_pulse(1'b0);
        pin(3, 1'b1);
        pin(12, 1'b1);
        // Timer 1 on companion overflow
        wr(`CCA_OFS_TCNT1, 32'h0000_0000);
        wr(va(13), 32'h0000_0003);
        wr(ca(13), cc(cca_pkg::CCA_FN_CMP, 2'h0, 1'b1, 1'b0, 1'b0));
        wr(`CCA_OFS_TCTL1, 32'h0000_0028);
        repeat (3) pm.ext_pulse(1'b1);
        nreq(13, 1);
        rd(`CCA_OFS_TCNT1, 32'h0000_0003);
        // Prescaler divide by 4, then staggered base every 8 clocks
        wr(`CCA_OFS_TCNT1, 32'h0000_0000);
        wr(`CCA_OFS_TCTL1, 32'h0000_0022);
        repeat (80) @(posedge clk_i);
        wr(`CCA_OFS_TCTL1, 32'h0000_0000);
        xfer(1'b0, `CCA_OFS_TCNT1, 32'h0000_0000, 4'hF);
        chk_rng(q, 18, 23);
        wr(`CCA_OFS_GCTL, 32'h0000_0001);
        wr(`CCA_OFS_TCNT1, 32'h0000_0000);
        wr(`CCA_OFS_TCTL1, 32'h0000_0020);
        repeat (80) @(posedge clk_i);
        wr(`CCA_OFS_TCTL1, 32'h0000_0000);
        xfer(1'b0, `CCA_OFS_TCNT1, 32'h0000_0000, 4'hF);
        chk_rng(q, 9, 12);
        complete_run();
    end

    // About 500 cycles are expected; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("Error at %0t: timeout", $time);
        complete_run();
    end
endmodule // test_capture_compare_array
`default_nettype wire

// ---- verilog/cca_map.svh ----
// Purpose: Offsets, field positions, reset values and counts of the capture/compare array
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one register per word
// Notes:   Definitions only
`ifndef CCA_MAP_SVH
`define CCA_MAP_SVH

`define CCA_NUM_CH      16
`define CCA_TW          16
`define CCA_STAG_DIV    8
// Register byte offsets
`define CCA_OFS_TCTL0   8'h00
`define CCA_OFS_TCTL1   8'h04
`define CCA_OFS_TCNT0   8'h08
`define CCA_OFS_TCNT1   8'h0C
`define CCA_OFS_TREL0   8'h10
`define CCA_OFS_TREL1   8'h14
`define CCA_OFS_GCTL    8'h18
`define CCA_OFS_PINS    8'h1C
`define CCA_OFS_CCTL    8'h40
`define CCA_OFS_CVAL    8'h80
// Timer control fields
`define CCA_TC_PRE_LSB  0
`define CCA_TC_SRC_LSB  3
`define CCA_TC_RUN      5
`define CCA_TC_W        6
// Timer clock sources
`define CCA_SRC_PRESC   2'h0
`define CCA_SRC_COMP    2'h1
`define CCA_SRC_EXT     2'h2
// Channel control fields
`define CCA_CC_FN_LSB   0
`define CCA_CC_MD_LSB   2
`define CCA_CC_TSEL     4
`define CCA_CC_SE       5
`define CCA_CC_DBL      6
`define CCA_CC_W        7
// Global control
`define CCA_GC_STAG     0
// Reset values and counter maximum
`define CCA_RST_TCTL    6'h00
`define CCA_RST_TREL    16'h0000
`define CCA_RST_CCTL    7'h00
`define CCA_CNT_MAX     16'hFFFF

`endif

// ---- verilog/cca_pkg.sv ----
// Purpose: Types of the capture/compare array
// Assumes: Constants come from cca_map.svh
// Notes:   Field codes of the function enum match the channel control layout
package cca_pkg;

    typedef enum logic [1:0] {
        CCA_FN_OFF,
        CCA_FN_CAP,
        CCA_FN_CMP,
        CCA_FN_RSV
    } cca_func_t;

    typedef struct packed {
        logic [6:0]  pre;
        logic [15:0] cnt;
        logic        step;
        logic        ovf;
    } cca_tmr_st_t;

    typedef struct packed {
        logic [1:0][5:0]   tctl;
        logic [1:0][15:0]  trel;
        logic              stag;
        logic [2:0]        stg;
        logic [15:0][6:0]  cctl;
        logic [15:0][15:0] cval;
        logic [15:0]       done;
        logic [15:0]       pin_prev;
        logic              cin_prev;
        logic [15:0]       pin_out;
        logic [15:0]       pin_oe;
        logic [15:0]       req;
        logic              ack;
        logic [31:0]       rdat;
    } cca_top_st_t;

endpackage

// ---- verilog/cca_timer.sv ----
// Purpose: One 16-bit reloading time base with prescaler
// Assumes: rst_i synchronous active high; all controls synchronous to clk_i
// Notes:   step and ovf are one-cycle pulses registered with the new count
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"
module cca_timer (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Array side
    cca_tmr_if.tmr     tif
);
    cca_pkg::cca_tmr_st_t q;
    cca_pkg::cca_tmr_st_t d;
    logic [6:0]           mask;
    logic                 tick;

    always_comb begin
        d      = q;
        d.step = 1'b0;
        d.ovf  = 1'b0;
        tick   = 1'b0;
        mask   = 7'((8'h01 << tif.presc) - 8'h01);
        if (tif.run && tif.base) begin
            d.pre = q.pre + 7'h01;
            if (!tif.use_ext && ((q.pre & mask) == mask)) begin
                tick = 1'b1;
            end
        end
        if (tif.run && tif.use_ext && tif.ext_tick) begin
            tick = 1'b1;
        end
        // Software write beats a count in the same cycle
        if (tif.load) begin
            d.cnt = tif.load_val;
        end else if (tick) begin
            d.step = 1'b1;
            if (q.cnt == `CCA_CNT_MAX) begin
                d.cnt = tif.rel;
                d.ovf = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.cnt  = q.cnt;
    assign tif.step = q.step;
    assign tif.ovf  = q.ovf;

    property p_reload;
        @(posedge clk_i) disable iff (rst_i)
        (tick && !tif.load && q.cnt == `CCA_CNT_MAX) |=> (tif.ovf && tif.cnt == $past(tif.rel));
    endproperty
    a_reload: assert property (p_reload) else $error("timer did not reload on overflow");

    property p_count;
        @(posedge clk_i) disable iff (rst_i)
        (tick && !tif.load && q.cnt != `CCA_CNT_MAX) |=> (tif.step && tif.cnt == $past(q.cnt) + 16'h0001);
    endproperty
    a_count: assert property (p_count) else $error("timer did not advance by one");

    property p_stopped;
        @(posedge clk_i) disable iff (rst_i)
        (!tif.run && !tif.load) |=> !tif.step;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer counted");
endmodule // cca_timer
`default_nettype wire

// ---- verilog/cca_tmr_if.sv ----
// Purpose: Control and status of one time base between the array and a timer
// Assumes: Single clock domain
// Notes:   ctl side is the array, tmr side the timer
`timescale 1ns/1ps
`default_nettype none
interface cca_tmr_if #(parameter int W = 16);
    logic [2:0]   presc;
    logic         use_ext;
    logic         ext_tick;
    logic         base;
    logic         run;
    logic         load;
    logic [W-1:0] load_val;
    logic [W-1:0] rel;
    logic [W-1:0] cnt;
    logic         step;
    logic         ovf;

    modport ctl (output presc, use_ext, ext_tick, base, run, load, load_val, rel,
                 input cnt, step, ovf);
    modport tmr (input presc, use_ext, ext_tick, base, run, load, load_val, rel,
                 output cnt, step, ovf);
endinterface
`default_nettype wire

// ---- verilog/cca_top.sv ----
// Purpose: Sixteen-channel capture/compare array on two time bases, Wishbone slave
// Assumes: clk_i 25 MHz; rst_i synchronous active high; pins synchronous to clk_i
// Notes:   Register access answers one cycle after the request, every address acked
//
// What this block does
// - Sixteen channels, one cycle or eight staggered
// - Two 16-bit timers with reload registers
// - Timer clock: prescaler or companion overflow
// - First timer may count external input
// - Each channel picks timer and capture/compare
// - One pin per channel, input or output
// - Mode zero: interrupt only, every match
// - Mode one: pin toggles every match
// - Mode two: one interrupt per period
// - Mode three: set on match, clear on overflow
// - Double register: two channels toggle one pin
// - Single event option stops after first match
// - Capture copies assigned timer into channel
// - Capture raises the channel's request
// - Capture edge: rising, falling or both
// - Compare on every count, act on equality
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cca_map.svh"
module cca_top #(
    parameter int NCH = `CCA_NUM_CH
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // Time base inputs
    input  wire logic        companion_timer_ovf_i,
    input  wire logic        count_i,
    // Channel pins and requests
    input  wire logic [15:0] pin_i,
    output logic [15:0]      pin_o,
    output logic [15:0]      pin_oe_o,
    output logic [15:0]      req_o
);
    cca_pkg::cca_top_st_t q;
    cca_pkg::cca_top_st_t d;
    cca_tmr_if #(.W(`CCA_TW)) tif [2] ();

    logic [1:0][15:0] tcnt;
    logic [1:0]       tstep;
    logic [1:0]       tovf;
    logic [1:0]       ext_tick;
    logic [1:0]       tload;
    logic             acc;
    logic             wr;
    logic [15:0]      cap_hit;
    logic [15:0]      cmp_hit;
    logic [15:0]      pin_evt;
    logic [1:0][31:0] load_m;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] fld2(input logic [6:0] c, input int lsb);
        return c[lsb +: 2];
    endfunction

    assign acc = wb_cyc_i && wb_stb_i && !q.ack;
    // Writes land at the edge where the master sees ack
    assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
    assign tload[0] = wr && (wb_adr_i == `CCA_OFS_TCNT0);
    assign tload[1] = wr && (wb_adr_i == `CCA_OFS_TCNT1);
    // First timer counts rising edges of the count input
    assign ext_tick[0] = (q.tctl[0][`CCA_TC_SRC_LSB +: 2] == `CCA_SRC_EXT)
                         ? (count_i && !q.cin_prev) : companion_timer_ovf_i;
    assign ext_tick[1] = (q.tctl[1][`CCA_TC_SRC_LSB +: 2] == `CCA_SRC_COMP)
                         && companion_timer_ovf_i;

    for (genvar t = 0; t < 2; t++) begin : g_tmr
        assign tif[t].presc    = q.tctl[t][`CCA_TC_PRE_LSB +: 3];
        assign tif[t].use_ext  = q.tctl[t][`CCA_TC_SRC_LSB +: 2] != `CCA_SRC_PRESC;
        assign tif[t].ext_tick = ext_tick[t];
        // Staggered operation coarsens the prescaler clock of both time bases to eight cycles
        assign tif[t].base     = !q.stag || (q.stg == 3'(`CCA_STAG_DIV - 1));
        assign tif[t].run      = q.tctl[t][`CCA_TC_RUN];
        assign tif[t].load     = tload[t];
        assign load_m[t]       = merge({16'h0000, tif[t].cnt}, wb_dat_i, wb_sel_i);
        assign tif[t].load_val = load_m[t][15:0];
        assign tif[t].rel      = q.trel[t];
        assign tcnt[t]  = tif[t].cnt;
        assign tstep[t] = tif[t].step;
        assign tovf[t]  = tif[t].ovf;
        cca_timer u_tmr (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .tif   (tif[t])
        );
    end

    always_comb begin
        logic [1:0]  fn;
        logic [1:0]  md;
        logic        ts;
        logic        own;
        logic [31:0] rd;
        fn         = 2'h0;
        md         = 2'h0;
        ts         = 1'b0;
        own        = 1'b0;
        rd         = 32'h0000_0000;
        d          = q;
        d.req      = '0;
        d.pin_prev = pin_i;
        d.cin_prev = count_i;
        d.stg      = q.stg + 3'h1;
        cap_hit    = '0;
        cmp_hit    = '0;
        pin_evt    = '0;
        for (int n = 0; n < NCH; n++) begin
            fn = fld2(q.cctl[n], `CCA_CC_FN_LSB);
            md = fld2(q.cctl[n], `CCA_CC_MD_LSB);
            ts = q.cctl[n][`CCA_CC_TSEL];
            if (fn == 2'(cca_pkg::CCA_FN_CAP)) begin
                cap_hit[n] = (md[0] && pin_i[n] && !q.pin_prev[n])
                          || (md[1] && !pin_i[n] && q.pin_prev[n]);
                if (cap_hit[n]) begin
                    d.cval[n] = tcnt[ts];
                    d.req[n]  = 1'b1;
                end
            end else if (fn == 2'(cca_pkg::CCA_FN_CMP)) begin
                // New period re-arms the once-per-period modes
                if (tovf[ts]) begin
                    d.done[n] = 1'b0;
                    if (md == 2'h3) begin
                        d.pin_out[n] = 1'b0;
                    end
                end
                cmp_hit[n] = tstep[ts] && (q.cval[n] == tcnt[ts])
                          && !(md[1] && q.done[n] && !tovf[ts]);
                if (cmp_hit[n]) begin
                    d.req[n] = 1'b1;
                    if (md[1]) begin
                        d.done[n] = 1'b1;
                    end
                    if (md == 2'h3) begin
                        d.pin_out[n] = 1'b1;
                    end
                    if (q.cctl[n][`CCA_CC_SE]) begin
                        d.cctl[n][`CCA_CC_FN_LSB +: 2] = 2'(cca_pkg::CCA_FN_OFF);
                    end
                end
            end
        end
        // Partner n+8 steers pin n, so its own pin is released
        for (int n = 0; n < NCH; n++) begin
            own = (n < NCH / 2) && q.cctl[n][`CCA_CC_DBL];
            md  = fld2(q.cctl[n], `CCA_CC_MD_LSB);
            pin_evt[n] = cmp_hit[n] && (md == 2'h1 || own);
            if (own) begin
                pin_evt[n] = pin_evt[n] || cmp_hit[n + NCH / 2];
            end
            if (pin_evt[n]) begin
                d.pin_out[n] = !q.pin_out[n];
            end
            d.pin_oe[n] = (fld2(q.cctl[n], `CCA_CC_FN_LSB) == 2'(cca_pkg::CCA_FN_CMP))
                          && (md[0] || own);
            if (n >= NCH / 2 && q.cctl[n - NCH / 2][`CCA_CC_DBL]) begin
                d.pin_oe[n] = 1'b0;
            end
        end
        // Bus access, answered one cycle after the request
        d.ack = acc;
        if (acc || wr) begin
            unique case (wb_adr_i)
                `CCA_OFS_TCTL0: rd = {26'h0, q.tctl[0]};
                `CCA_OFS_TCTL1: rd = {26'h0, q.tctl[1]};
                `CCA_OFS_TCNT0: rd = {16'h0, tcnt[0]};
                `CCA_OFS_TCNT1: rd = {16'h0, tcnt[1]};
                `CCA_OFS_TREL0: rd = {16'h0, q.trel[0]};
                `CCA_OFS_TREL1: rd = {16'h0, q.trel[1]};
                `CCA_OFS_GCTL:  rd = {31'h0, q.stag};
                `CCA_OFS_PINS:  rd = {q.pin_out, pin_i};
                default: begin
                    if (wb_adr_i[7:6] == 2'h1) begin
                        rd = {25'h0, q.cctl[wb_adr_i[5:2]]};
                    end else if (wb_adr_i[7:6] == 2'h2) begin
                        rd = {16'h0, q.cval[wb_adr_i[5:2]]};
                    end
                end
            endcase
            if (acc) begin
                d.rdat = rd;
            end
            if (wr) begin
                rd = merge(rd, wb_dat_i, wb_sel_i);
                unique case (wb_adr_i)
                    `CCA_OFS_TCTL0: d.tctl[0] = rd[5:0];
                    `CCA_OFS_TCTL1: d.tctl[1] = rd[5:0];
                    `CCA_OFS_TREL0: d.trel[0] = rd[15:0];
                    `CCA_OFS_TREL1: d.trel[1] = rd[15:0];
                    `CCA_OFS_GCTL:  d.stag    = rd[`CCA_GC_STAG];
                    default: begin
                        if (wb_adr_i[7:6] == 2'h1) begin
                            d.cctl[wb_adr_i[5:2]] = rd[6:0];
                            d.done[wb_adr_i[5:2]] = 1'b0;
                        end else if (wb_adr_i[7:6] == 2'h2) begin
                            d.cval[wb_adr_i[5:2]] = rd[15:0];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign pin_o    = q.pin_out;
    assign pin_oe_o = q.pin_oe;
    assign req_o    = q.req;

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_wb_ack;
        @(posedge clk_i) disable iff (rst_i)
        s_req |=> s_ack_once;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack not a single cycle pulse");

    for (genvar n = 0; n < 16; n++) begin : g_chk
        property p_cap_val;
            @(posedge clk_i) disable iff (rst_i)
            cap_hit[n] |=> q.cval[n] == $past(tcnt[q.cctl[n][`CCA_CC_TSEL]]);
        endproperty
        a_cap_val: assert property (p_cap_val) else $error("capture value wrong");

        property p_cap_req;
            @(posedge clk_i) disable iff (rst_i)
            cap_hit[n] |=> req_o[n] ##1 (!req_o[n] || $past(cap_hit[n] || cmp_hit[n]));
        endproperty
        a_cap_req: assert property (p_cap_req) else $error("capture request missing");

        property p_toggle;
            @(posedge clk_i) disable iff (rst_i)
            pin_evt[n] |=> pin_o[n] != $past(pin_o[n]);
        endproperty
        a_toggle: assert property (p_toggle) else $error("pin did not toggle");

        property p_set3;
            @(posedge clk_i) disable iff (rst_i)
            (cmp_hit[n] && fld2(q.cctl[n], `CCA_CC_MD_LSB) == 2'h3
             && !q.cctl[n][`CCA_CC_DBL]) |=> pin_o[n] && req_o[n];
        endproperty
        a_set3: assert property (p_set3) else $error("mode three pin not set");

        property p_once;
            @(posedge clk_i) disable iff (rst_i)
            (q.done[n] && !tovf[q.cctl[n][`CCA_CC_TSEL]]) |-> !cmp_hit[n];
        endproperty
        a_once: assert property (p_once) else $error("second event in one period");

        property p_mode0;
            @(posedge clk_i) disable iff (rst_i)
            (cmp_hit[n] && fld2(q.cctl[n], `CCA_CC_MD_LSB) == 2'h0 && !pin_evt[n])
            |=> $stable(pin_o[n]) && req_o[n];
        endproperty
        a_mode0: assert property (p_mode0) else $error("mode zero moved the pin");

        property p_single;
            @(posedge clk_i) disable iff (rst_i)
            (cmp_hit[n] && q.cctl[n][`CCA_CC_SE] && !wr)
            |=> fld2(q.cctl[n], `CCA_CC_FN_LSB) == 2'h0 ##1 !cmp_hit[n];
        endproperty
        a_single: assert property (p_single) else $error("single event repeated");
    end
endmodule // cca_top
`default_nettype wire
